// File: pkg/gsa_pkg.sv
// Shared constants for the gauge state-of-charge flag and alert block.
// Assumes a 50 MHz clock and an AHB-Lite register port with 32-bit words.
//
// Behaviour
// - Polarity bit inverts or passes alert output
// - Mode bit selects level indicator or pulses
// - Indicator mode follows first low-charge flag
// - First flag sets below, clears above threshold
// - Final flag uses separate set, clear levels
// - Interrupt events give 1 ms pulses; events during a busy pulse share one pulse after it
// - Charging pulses above step points and 100
// - Discharging pulses at step points down to 0
// - Charge and state pulses need nonzero step
// - Charge or discharge entry pulses, relax not
// - Removal on detect pin pulses when enabled
// - Insertion plus init done enters normal gauging
// - Smoothing filters charge output only when enabled
// - Current thresholds are capacity over 13.3/16.7/25
// - Charge accumulates sensed current into charge
// - Chemical capacity starts from design capacity
package gsa_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] GSA_OFF_CONFIG    = 8'h00; // Operation config bits
    localparam logic [7:0] GSA_OFF_LEVELS    = 8'h04; // Threshold levels and step
    localparam logic [7:0] GSA_OFF_CAPACITY  = 8'h08; // Design capacity
    localparam logic [7:0] GSA_OFF_SUBCMD    = 8'h0c; // Insert/remove subcommands
    localparam logic [7:0] GSA_OFF_SENSE     = 8'h10; // Signed sensed charge sample
    localparam logic [7:0] GSA_OFF_STATUS    = 8'h14; // Flags, state, percent
    localparam logic [7:0] GSA_OFF_THRESH    = 8'h18; // Derived current thresholds
    localparam logic [7:0] GSA_OFF_QMAX      = 8'h1c; // Chemical capacity

    // ----------------------------------------------------------------
    // Config field positions
    // ----------------------------------------------------------------
    localparam int GSA_CFG_POL    = 0; // Alert polarity select
    localparam int GSA_CFG_LOWEN  = 1; // Low battery mode enable
    localparam int GSA_CFG_BIE    = 2; // Insert detect enable
    localparam int GSA_CFG_SMOOTH = 3; // Smoothing enable
    localparam int GSA_CFG_INITOK = 4; // Initialization complete

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [4:0]  GSA_RST_CONFIG   = 5'h00;
    localparam logic [6:0]  GSA_RST_FIRST    = 7'h0f; // First set level
    localparam logic [6:0]  GSA_RST_FINSET   = 7'h02; // Final set level
    localparam logic [6:0]  GSA_RST_FINCLR   = 7'h05; // Final clear level
    localparam logic [6:0]  GSA_RST_STEP     = 7'h01; // One percent step
    localparam logic [15:0] GSA_RST_CAPACITY = 16'h03e8;
    localparam logic [6:0]  GSA_FULL         = 7'h64; // 100 percent

    // ----------------------------------------------------------------
    // Subcommand codes
    // ----------------------------------------------------------------
    localparam logic [7:0] GSA_SUB_INSERT = 8'h0c;
    localparam logic [7:0] GSA_SUB_REMOVE = 8'h0d;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int GSA_CLK_HZ       = 50000000;
    localparam int GSA_PULSE_US     = 1000;
    localparam int GSA_PULSE_CYC    = GSA_CLK_HZ / 1000000 * GSA_PULSE_US;

    // Battery state classification
    typedef enum logic [1:0] {
        GSA_RELAX = 2'b00,
        GSA_CHG   = 2'b01,
        GSA_DSG   = 2'b10
    } gsa_bstate_t;

    // Operating mode
    typedef enum logic [0:0] {
        GSA_INIT   = 1'b0,
        GSA_NORMAL = 1'b1
    } gsa_mode_t;

endpackage : gsa_pkg

// File: core/gsa_pulse.sv
// One-shot alert pulse timer.
// Assumes triggers on the same clock; retriggers while busy are held pending.
`timescale 1ns/1ps
module gsa_pulse
    import gsa_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Event request and pulse out
    input  wire logic trig,
    output logic      active
);

    // ----------------------------------------------------------------
    // Pulse counter
    // ----------------------------------------------------------------
    localparam int CW = $clog2(GSA_PULSE_CYC + 1);
    logic [CW-1:0] count;    // Cycles left in pulse
    logic          pending;  // Event seen while busy
    logic          gap;      // Blocks a start for one cycle after a pulse ends

    wire start = (trig | pending) & (count == '0) & ~gap;

    // Events during a pulse merge into one pending pulse that waits for the gap, so the host counts two
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count   <= '0;
            pending <= 1'b0;
            gap     <= 1'b0;
        end else begin
            gap <= (count == CW'(1));
            if (start) begin
                count   <= CW'(GSA_PULSE_CYC);
                pending <= 1'b0;
            end else begin
                if (count != '0) count <= count - CW'(1);
                if (trig) pending <= 1'b1;
            end
        end
    end

    assign active = (count != '0);

    a_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(active) |-> active [*8])
        else $error("alert pulse shorter than expected");

endmodule : gsa_pulse

// File: core/gsa_alert.sv
// Gauge state-of-charge flags, alert output and battery detection.
// Assumes an AHB-Lite master on hclk and an asynchronous detect pin.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module gsa_alert
    import gsa_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pins
    input  wire logic        battery_detect_in,
    output logic             alert_output
);

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    logic [4:0]  operation_config;        // Config bits
    logic [6:0]  first_low_set_level;     // First flag level
    logic [6:0]  final_low_set_level;     // Final flag set level
    logic [6:0]  final_low_clear_level;   // Final flag clear level
    logic [6:0]  irq_step_size;           // Interrupt step size
    logic [15:0] design_capacity;         // Design capacity, mAh

    wire alert_polarity_sel = operation_config[GSA_CFG_POL];
    wire low_batt_mode_en   = operation_config[GSA_CFG_LOWEN];
    wire insert_detect_en   = operation_config[GSA_CFG_BIE];
    wire smoothing_en       = operation_config[GSA_CFG_SMOOTH];
    wire init_done          = operation_config[GSA_CFG_INITOK];

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    logic       wr_pend;   // Write data phase pending
    logic [7:0] wr_addr;   // Captured write offset
    logic [7:0] rd_addr;   // Captured read offset
    logic       rd_pend;

    wire        take   = hsel & hready & htrans[1];
    wire        wr_now = wr_pend;
    wire        sub_wr = wr_now & (wr_addr == GSA_OFF_SUBCMD);
    wire        sns_wr = wr_now & (wr_addr == GSA_OFF_SENSE);

    // Zero-wait slave, single words only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Config registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operation_config      <= GSA_RST_CONFIG;
            first_low_set_level   <= GSA_RST_FIRST;
            final_low_set_level   <= GSA_RST_FINSET;
            final_low_clear_level <= GSA_RST_FINCLR;
            irq_step_size         <= GSA_RST_STEP;
            design_capacity       <= GSA_RST_CAPACITY;
        end else if (wr_now) begin
            case (wr_addr)
                GSA_OFF_CONFIG: operation_config <= hwdata[4:0];
                GSA_OFF_LEVELS: begin
                    first_low_set_level   <= hwdata[6:0];
                    final_low_set_level   <= hwdata[14:8];
                    final_low_clear_level <= hwdata[22:16];
                    irq_step_size         <= hwdata[30:24];
                end
                GSA_OFF_CAPACITY: design_capacity <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Detect pin synchroniser and insertion state
    // ----------------------------------------------------------------
    logic det_s1, det_s2, det_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_s1 <= 1'b1;
            det_s2 <= 1'b1;
            det_d  <= 1'b1;
        end else begin
            det_s1 <= battery_detect_in;
            det_s2 <= det_s1;
            det_d  <= det_s2;
        end
    end

    // Pin edges count only with pin detection on; subcommands otherwise
    wire pin_insert = insert_detect_en & det_d & ~det_s2;
    wire pin_remove = insert_detect_en & ~det_d & det_s2;
    wire cmd_insert = ~insert_detect_en & sub_wr & (hwdata[7:0] == GSA_SUB_INSERT);
    wire cmd_remove = ~insert_detect_en & sub_wr & (hwdata[7:0] == GSA_SUB_REMOVE);

    logic      inserted;  // Battery present
    gsa_mode_t mode;      // Init or normal gauging
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inserted <= 1'b0;
            mode     <= GSA_INIT;
        end else begin
            if (pin_insert | cmd_insert) inserted <= 1'b1;
            else if (pin_remove | cmd_remove) inserted <= 1'b0;
            case (mode)
                GSA_INIT:   if (inserted & init_done) mode <= GSA_NORMAL;
                GSA_NORMAL: if (~inserted) mode <= GSA_INIT;
                default:    mode <= GSA_INIT;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Current thresholds and capacity
    // ----------------------------------------------------------------
    // Divisors scaled by ten keep the decimal figures exact
    wire [19:0] cap_x10    = 20'(design_capacity) * 20'd10;
    wire [15:0] chg_thresh = 16'(cap_x10 / 20'd133);
    wire [15:0] dsg_thresh = 16'(cap_x10 / 20'd167);
    wire [15:0] qut_thresh = 16'(cap_x10 / 20'd250);

    logic [15:0] qmax;  // Chemical capacity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) qmax <= GSA_RST_CAPACITY;
        else if (mode == GSA_INIT) qmax <= design_capacity;
    end

    // ----------------------------------------------------------------
    // Charge accumulation from sensed current
    // ----------------------------------------------------------------
    // Each write to the sense register is one sample of signed charge, mAh
    wire signed [15:0] sample  = signed'(hwdata[15:0]);
    wire signed [15:0] mag_s   = sample[15] ? -sample : sample;
    wire        [15:0] mag     = 16'(mag_s);
    logic signed [23:0] remcap;   // Remaining capacity, mAh
    logic  [6:0]        raw_pct;  // Unfiltered percent
    logic  [6:0]        charge_percent_value;
    logic               upd;      // Percent updated this cycle
    gsa_bstate_t        bstate;
    wire                gauging = (mode == GSA_NORMAL) & sns_wr;

    wire signed [23:0] acc_sum = remcap + 24'(sample);
    wire signed [23:0] acc_lim = acc_sum[23] ? 24'sd0 :
                                 (acc_sum > 24'(qmax)) ? 24'(qmax) : acc_sum;
    wire [31:0] pct_num  = 32'(acc_lim) * 32'd100;
    wire [6:0]  pct_new  = (qmax == 16'h0000) ? 7'h00 : 7'(pct_num / 32'(qmax));

    wire gsa_bstate_t next_bstate =
        (~sample[15] & (mag > chg_thresh)) ? GSA_CHG :
        ( sample[15] & (mag > dsg_thresh)) ? GSA_DSG :
        (mag < qut_thresh) ? GSA_RELAX : bstate;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remcap  <= 24'sd0;
            raw_pct <= 7'h00;
            bstate  <= GSA_RELAX;
        end else if (gauging) begin
            remcap  <= acc_lim;
            raw_pct <= pct_new;
            bstate  <= next_bstate;
        end
    end

    // Smoothing walks the reported value one percent per update
    wire [6:0] next_pct = ~smoothing_en ? raw_pct :
                          (raw_pct > charge_percent_value) ? charge_percent_value + 7'h01 :
                          (raw_pct < charge_percent_value) ? charge_percent_value - 7'h01 :
                          charge_percent_value;
    logic gauged_d;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            charge_percent_value <= 7'h00;
            gauged_d             <= 1'b0;
        end else begin
            gauged_d <= gauging;
            if (gauged_d) charge_percent_value <= next_pct;
        end
    end
    assign upd = gauged_d;

    // ----------------------------------------------------------------
    // Low-charge flags
    // ----------------------------------------------------------------
    logic first_low_charge_flag, final_low_charge_flag;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_low_charge_flag <= 1'b0;
            final_low_charge_flag <= 1'b0;
        end else if (upd) begin
            if (next_pct < first_low_set_level) first_low_charge_flag <= 1'b1;
            else if (next_pct > first_low_set_level) first_low_charge_flag <= 1'b0;
            if (next_pct < final_low_set_level) final_low_charge_flag <= 1'b1;
            else if (final_low_charge_flag & (next_pct > final_low_clear_level))
                final_low_charge_flag <= 1'b0;
        end
    end
    wire low_batt_indicator = first_low_charge_flag;

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    // A point is 100 - n*step; distance below full is a multiple of step
    wire        step_on  = (irq_step_size != 7'h00);
    wire [6:0]  old_pct  = charge_percent_value;
    wire [6:0]  dist_new = GSA_FULL - next_pct;
    wire [6:0]  dist_old = GSA_FULL - old_pct;
    wire [6:0]  idx_new  = step_on ? dist_new / irq_step_size : 7'h00;
    wire [6:0]  idx_old  = step_on ? dist_old / irq_step_size : 7'h00;
    wire        on_pt    = step_on & (dist_new % irq_step_size == 7'h00);
    // Rising: crossed above a point, or reached full
    wire        up_evt   = (next_pct > old_pct) &
                           ((idx_new < idx_old) | (next_pct == GSA_FULL));
    // Falling: reached or passed a point, or hit zero
    wire        dn_evt   = (next_pct < old_pct) &
                           (((idx_new > idx_old) | on_pt) | (next_pct == 7'h00));
    wire        soc_evt  = upd & step_on & (up_evt | dn_evt);
    gsa_bstate_t bstate_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) bstate_q <= GSA_RELAX;
        else bstate_q <= bstate;
    end
    wire st_evt  = step_on & (bstate != bstate_q) & (bstate != GSA_RELAX);
    wire int_evt = ~low_batt_mode_en & (soc_evt | st_evt | pin_remove);

    logic pulse_on;
    gsa_pulse u_pulse (
        .hclk    (hclk),
        .hresetn (hresetn),
        .trig    (int_evt),
        .active  (pulse_on)
    );

    // ----------------------------------------------------------------
    // Alert output
    // ----------------------------------------------------------------
    wire alert_raw = low_batt_mode_en ? low_batt_indicator : pulse_on;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) alert_output <= 1'b0;
        else alert_output <= alert_raw ^ alert_polarity_sel;
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire [31:0] rd_mux =
        (rd_addr == GSA_OFF_CONFIG)   ? {27'h0, operation_config} :
        (rd_addr == GSA_OFF_LEVELS)   ? {1'b0, irq_step_size, 1'b0, final_low_clear_level,
                                         1'b0, final_low_set_level, 1'b0, first_low_set_level} :
        (rd_addr == GSA_OFF_CAPACITY) ? {16'h0, design_capacity} :
        (rd_addr == GSA_OFF_STATUS)   ? {16'h0, charge_percent_value, mode, bstate,
                                         inserted, final_low_charge_flag,
                                         first_low_charge_flag, det_s2, 2'b00} :
        (rd_addr == GSA_OFF_THRESH)   ? {chg_thresh[9:0], dsg_thresh[9:0], 2'b00,
                                         qut_thresh[9:0]} :
        (rd_addr == GSA_OFF_QMAX)     ? {16'h0, qmax} : 32'h0;
    // Read data sampled combinationally in data phase from captured address
    assign hrdata = rd_pend ? rd_mux : 32'h0;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_polarity_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        low_batt_mode_en && $stable(low_batt_mode_en) && $stable(alert_polarity_sel)
        |=> alert_output == ($past(first_low_charge_flag) ^ $past(alert_polarity_sel)))
        else $error("indicator alert wrong level");
    a_first_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        upd && next_pct < first_low_set_level |=> first_low_charge_flag)
        else $error("first flag not set");
    a_final_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        upd && final_low_charge_flag && next_pct <= final_low_clear_level
        |=> final_low_charge_flag)
        else $error("final flag cleared early");
    a_step_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        !step_on |-> !soc_evt && !st_evt)
        else $error("event with zero step");
    a_relax_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        bstate == GSA_RELAX |-> !st_evt)
        else $error("relax entry pulsed");
    a_mode_init: assert property (@(posedge hclk) disable iff (!hresetn)
        !inserted |=> mode == GSA_INIT)
        else $error("normal without battery");
    a_pulse_level: assert property (@(posedge hclk) disable iff (!hresetn)
        !low_batt_mode_en && $stable(low_batt_mode_en) && $stable(alert_polarity_sel)
        |=> alert_output == ($past(pulse_on) ^ $past(alert_polarity_sel)))
        else $error("pulse alert wrong level");
    a_remove_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        pin_remove && !low_batt_mode_en |-> int_evt)
        else $error("removal not signalled");

endmodule : gsa_alert

// File: test/gsa_host.sv
// Host side model: watches the alert pin and drives the battery detect pin.
// Assumes alert pulses are active high (polarity bit clear) while counted.
`timescale 1ns/1ps
module gsa_host (
    // Clock
    input  wire logic hclk,
    // Pins
    input  wire logic alert_output,
    output logic      battery_detect_in,
    // Pulse statistics
    output int        pulses,
    output int        width
);
    int run; // Length of the current high run

    // Pull-up keeps the pin high until a pack is fitted
    initial begin
        battery_detect_in = 1'b1;
        pulses = 0;
        width = 0;
        run = 0;
    end

    // Pin moves just after an edge: low inserts, high removes
    task automatic set_pin(input logic v);
        @(posedge hclk);
        battery_detect_in <= v;
    endtask : set_pin

    // Count high cycles; a falling edge closes one pulse
    always @(posedge hclk) begin
        if (alert_output === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
endmodule : gsa_host

// File: test/tb.sv
// Self-checking bench for the alert block over AHB-Lite.
// Assumes zero wait states are not relied on; every wait is bounded.
`timescale 1ns/1ps
module tb;
    import gsa_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, bdet, alert;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          mismatches, comparisons, pulses, width, n, p0;

    gsa_alert dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .battery_detect_in(bdet), .alert_output(alert));
    gsa_host hs (.hclk(hclk), .alert_output(alert), .battery_detect_in(bdet),
        .pulses(pulses), .width(width));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Verdict and checks
    // ------------------------------------------------------------
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Sample mid-cycle so values equal those at the next edge, no race
    task automatic wait_rdy(output logic [31:0] d);
        logic ok;
        n = 0;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            d = hrdata;
            @(posedge hclk);
            n++;
        end while (ok !== 1'b1 && n < 100);
        if (ok !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask : wait_rdy

    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'b010;
        wait_rdy(q);
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(q);
    endtask : bus

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(1'b0, GSA_OFF_LEVELS, 32'h0);
        chk("levels", q, 32'h0105020f);
        bus(1'b0, GSA_OFF_QMAX, 32'h0);
        chk("qmax", q, 32'h000003e8);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
        chk("okay resp", {31'h0, hresp}, 32'h0);
        bus(1'b0, GSA_OFF_THRESH, 32'h0);
        chk("thresholds", q, 32'h12c3b028);
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("init mode", {31'h0, q[8]}, 32'h0);
    endtask : t_reset

    // Polarity applies to both functions; indicator follows first flag
    task automatic t_polarity();
        bus(1'b1, GSA_OFF_CONFIG, 32'h11);
        repeat (2) @(posedge hclk);
        chk("idle inverted", {31'h0, alert}, 32'h1);
        bus(1'b1, GSA_OFF_CONFIG, 32'h13);
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("indicator inv", {31'h0, alert}, 32'h1);
        bus(1'b1, GSA_OFF_CONFIG, 32'h12);
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("indicator", {31'h0, alert}, 32'h0);
    endtask : t_polarity

    // Pin insertion reaches normal mode; removal gives one 1 ms pulse
    task automatic t_pin();
        bus(1'b1, GSA_OFF_CONFIG, 32'h14);
        hs.set_pin(1'b0);
        repeat (4) @(posedge hclk);
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("normal mode", {31'h0, q[8]}, 32'h1);
        p0 = pulses;
        hs.set_pin(1'b1);
        for (n = 0; n < 60000 && pulses == p0; n++) @(posedge hclk);
        chk("pulse count", 32'(pulses), 32'(p0 + 1));
        chk("pulse width", 32'(width), 32'(GSA_PULSE_CYC));
        if (pulses == p0) final_report();
        bus(1'b1, GSA_OFF_CONFIG, 32'h10);
        hs.set_pin(1'b0);
        hs.set_pin(1'b1);
        repeat (100) @(posedge hclk);
        chk("no pin pulse", 32'(pulses), 32'(p0 + 1));
    endtask : t_pin

    // Subcommand insertion needs the init-done bit before normal mode
    task automatic t_mode();
        bus(1'b1, GSA_OFF_CONFIG, 32'h00);
        bus(1'b1, GSA_OFF_SUBCMD, {24'h0, GSA_SUB_INSERT});
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("inserted", {30'h0, q[8], q[5]}, 32'h1);
        bus(1'b1, GSA_OFF_CONFIG, 32'h10);
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
        chk("mode done", {31'h0, q[8]}, 32'h1);
    endtask : t_mode

    // One charge sample, then a status read
    task automatic gauge(input logic [15:0] s);
        bus(1'b1, GSA_OFF_SENSE, {16'h0, s});
        bus(1'b0, GSA_OFF_STATUS, 32'h0);
    endtask : gauge

    // Capacity 1000: samples walk percent through both flag levels
    task automatic t_gauge();
        gauge(16'h01f4);
        chk("percent", {25'h0, q[15:9]}, 32'd50);
        chk("charging", {30'h0, q[7:6]}, 32'h1);
        repeat (2) @(posedge hclk);
        chk("charge pulse", {31'h0, alert}, 32'h1);
        gauge(16'hfe70);
        chk("first set", {30'h0, q[4:3]}, 32'h1);
        chk("discharging", {30'h0, q[7:6]}, 32'h2);
        gauge(16'hffa6);
        chk("final set", {30'h0, q[4:3]}, 32'h3);
        gauge(16'h001e);
        chk("final held", {30'h0, q[4:3]}, 32'h3);
        gauge(16'h0014);
        chk("final clear", {30'h0, q[4:3]}, 32'h1);
        bus(1'b1, GSA_OFF_CONFIG, 32'h18);
        gauge(16'h00c8);
        chk("smoothed", {25'h0, q[15:9]}, 32'd7);
        bus(1'b1, GSA_OFF_CONFIG, 32'h12);
        repeat (2) @(posedge hclk);
        chk("low indicator", {31'h0, alert}, 32'h1);
    endtask : t_gauge

    initial begin
        mismatches = 0;
        comparisons = 0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_polarity();
        t_pin();
        t_mode();
        t_gauge();
        final_report();
    end
endmodule : tb
